// ---- core/aux_ctrl.sv ----
// Contract
// - Timer counts down each timer tick while run bit is high and count is nonzero, holds otherwise.
// - Writing zero to run bit stops the timer.
// - Load bit issues a load pulse and self-clears when the load completes.
// - Prescale bit picks CPU clock over sixteen (0) or over two (1).
// - Direction bit makes interrupt pin input (0) or output (1).
// - Clock output disable high leaves clock output pin undriven.
// - Remote lockout high refuses every remote host access.
// - Global enable low blocks all maskable interrupts.
// - Global enable high passes interrupts whose mask bit is clear.
// - Slow-read bit makes data reads take four T-states, not three.
// - Slow-read bit delays read strobe fall after bus release.
// - Remote interface configuration is not in the CPU register map.
// - Pin as output is driven from the fourth mask bit.
// - Timeout set at zero; cleared by writing one or stopping timer.
`include "aux_ctrl_map.svh"
`default_nettype none
module aux_ctrl
  import aux_ctrl_pkg::*;
#(
  parameter int TIMER_WIDTH = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        reg_wr,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [4:0]  irq_requests,
  output logic             irq_take,
  output logic      [4:0]  irq_accepted,
  input  wire logic        bidir_interrupt_pin_in,
  output logic             bidir_interrupt_pin_out,
  output logic             bidir_interrupt_pin_oe,
  input  wire logic        cpu_clk_level,
  output logic             clk_out_pin_out,
  output logic             clk_out_pin_oe,
  input  wire logic        remote_req,
  output logic             remote_grant,
  output logic      [2:0]  read_tstates,
  output logic             read_strobe_delay
);

  if (TIMER_WIDTH != 16) begin : g_width_check
    $error("TIMER_WIDTH must be 16");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]             auxiliary_control_ff;
  logic [7:0]             interrupt_control_ff;
  logic [7:0]             timer_low_byte_ff;
  logic [7:0]             timer_high_byte_ff;
  logic [TIMER_WIDTH-1:0] count_ff;
  logic                   timeout_flag_ff;
  logic [3:0]             div_ff;
  logic                   pin_meta_ff;
  logic                   pin_sync_ff;
  logic                   remote_meta_ff;
  logic                   remote_sync_ff;
  load_state_t            load_state_ff;

  logic wr_aux;
  logic timer_tick;
  logic load_pulse;
  logic timer_run;
  logic irq_pin_direction;
  logic hit_zero;

  assign wr_aux            = reg_wr && (reg_addr == `AUX_CTRL_ADDR);
  assign timer_run         = auxiliary_control_ff[`AUX_RUN_BIT];
  assign irq_pin_direction = auxiliary_control_ff[`AUX_DIR_BIT];
  assign load_pulse        = (load_state_ff == load_wait_t_s);

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      interrupt_control_ff <= `INT_CTRL_RESET;
      timer_low_byte_ff    <= 8'h00;
      timer_high_byte_ff   <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `INT_CTRL_ADDR) interrupt_control_ff <= reg_wdata;
      if (reg_addr == `TMR_LOW_ADDR) timer_low_byte_ff <= reg_wdata;
      if (reg_addr == `TMR_HIGH_ADDR) timer_high_byte_ff <= reg_wdata;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Load bit self-clears after the load pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      auxiliary_control_ff <= `AUX_CTRL_RESET;
    end else if (wr_aux) begin
      auxiliary_control_ff <= reg_wdata;
    end else if (load_pulse) begin
      auxiliary_control_ff[`AUX_LOAD_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // Load sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      load_state_ff <= load_idle_t_s;
    end else begin
      unique case (load_state_ff)
        load_idle_t_s: begin
          if (wr_aux && reg_wdata[`AUX_LOAD_BIT]) load_state_ff <= load_wait_t_s;
        end
        // A load request written during the pulse stretches that pulse by one more cycle
        load_wait_t_s: begin
          if (wr_aux && reg_wdata[`AUX_LOAD_BIT]) load_state_ff <= load_wait_t_s;
          else load_state_ff <= load_idle_t_s;
        end
        default:       load_state_ff <= load_idle_t_s;
      endcase
    end
  end

  // ****************************************
  // Timer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset || !timer_run) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  localparam int FAST_MASK = `DIV_FAST - 1;

  assign timer_tick = timer_run && (auxiliary_control_ff[`AUX_PRESCALE_BIT]
                      ? ((div_ff & 4'(FAST_MASK)) == 4'(FAST_MASK))
                      : (div_ff == 4'(`DIV_SLOW - 1)));

  assign hit_zero = timer_tick && !load_pulse && (count_ff == 16'h0001);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_ff <= 16'h0000;
    end else if (load_pulse) begin
      count_ff <= {timer_high_byte_ff, timer_low_byte_ff};
    end else if (timer_tick && count_ff != 16'h0000) begin
      count_ff <= count_ff - 16'h0001;
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timeout_flag_ff <= 1'b0;
    end else if (hit_zero) begin
      timeout_flag_ff <= 1'b1;
    end else if (wr_aux && !reg_wdata[`AUX_RUN_BIT]) begin
      timeout_flag_ff <= 1'b0;
    end else if (reg_wr && reg_addr == `COND_CODE_ADDR && reg_wdata[`CCR_TIMEOUT_BIT]) begin
      timeout_flag_ff <= 1'b0;
    end
  end

  // ****************************************
  // Pins and interrupts
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= bidir_interrupt_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Remote request is asynchronous to the CPU clock
  always_ff @(posedge ref_clk) begin
    remote_meta_ff <= remote_req;
    remote_sync_ff <= remote_meta_ff;
  end

  assign bidir_interrupt_pin_oe  = irq_pin_direction;
  assign bidir_interrupt_pin_out = interrupt_control_ff[`IMASK_PIN_BIT];
  assign clk_out_pin_oe  = !auxiliary_control_ff[`AUX_CLKDIS_BIT];
  assign clk_out_pin_out = cpu_clk_level;
  assign remote_grant    = remote_sync_ff && !auxiliary_control_ff[`AUX_LOCK_BIT];

  logic [4:0] eff_mask;
  always_comb begin
    eff_mask    = interrupt_control_ff[4:0];
    eff_mask[3] = interrupt_control_ff[3] && !irq_pin_direction;
  end

  always_comb begin
    irq_accepted = '0;
    if (auxiliary_control_ff[`AUX_IRQ_EN_BIT]) begin
      irq_accepted = irq_requests & ~eff_mask;
    end
  end
  assign irq_take = |irq_accepted;

  // ****************************************
  // Read timing outputs
  // ****************************************
  assign read_tstates = auxiliary_control_ff[`AUX_SLOW_BIT]
                        ? 3'(`READ_TSTATES_SLOW) : 3'(`READ_TSTATES_NORMAL);
  assign read_strobe_delay = auxiliary_control_ff[`AUX_SLOW_BIT];

  // ****************************************
  // Register read-back
  // ****************************************
  always_comb begin
    unique case (reg_addr)
      `AUX_CTRL_ADDR: reg_rdata = auxiliary_control_ff;
      `INT_CTRL_ADDR: reg_rdata = interrupt_control_ff;
      `TMR_LOW_ADDR:  reg_rdata = count_ff[7:0];
      `TMR_HIGH_ADDR: reg_rdata = count_ff[15:8];
      `COND_CODE_ADDR: reg_rdata = {timeout_flag_ff, 2'b00, pin_sync_ff, 4'h0};
      default:        reg_rdata = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// ---- core/aux_ctrl_map.svh ----
`ifndef AUX_CTRL_MAP_SVH
`define AUX_CTRL_MAP_SVH
// ****************************************
// Register addresses (main bank)
// ****************************************
`define AUX_CTRL_ADDR       5'h03
`define INT_CTRL_ADDR       5'h02
`define COND_CODE_ADDR      5'h00
`define TMR_LOW_ADDR        5'h04
`define TMR_HIGH_ADDR       5'h05
// ****************************************
// Auxiliary control fields
// ****************************************
`define AUX_RUN_BIT         7
`define AUX_LOAD_BIT        6
`define AUX_PRESCALE_BIT    5
`define AUX_DIR_BIT         4
`define AUX_SLOW_BIT        3
`define AUX_CLKDIS_BIT      2
`define AUX_LOCK_BIT        1
`define AUX_IRQ_EN_BIT      0
`define AUX_CTRL_RESET      8'h00
`define INT_CTRL_RESET      8'h00
`define IMASK_PIN_BIT       3
`define CCR_TIMEOUT_BIT     7
`define CCR_IRQPIN_BIT      4
// ****************************************
// Timing
// ****************************************
`define DIV_SLOW            16
`define DIV_FAST            2
`define READ_TSTATES_NORMAL 3
`define READ_TSTATES_SLOW   4
`endif

// ---- core/aux_ctrl_pkg.sv ----
`default_nettype none
package aux_ctrl_pkg;
  typedef enum logic [1:0] {
    load_idle_t_s = 2'b00,
    load_wait_t_s = 2'b01
  } load_state_t;
endpackage
`default_nettype wire

// ---- tb/aux_ctrl_chk.sv ----
`default_nettype none
module aux_ctrl_chk (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [4:0] irq_requests,
  input wire logic [4:0] irq_accepted,
  input wire logic       bidir_interrupt_pin_out,
  input wire logic       bidir_interrupt_pin_oe,
  input wire logic       clk_out_pin_oe,
  input wire logic       remote_req,
  input wire logic       remote_grant,
  input wire logic [2:0] read_tstates,
  input wire logic       read_strobe_delay
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Shadow copies of the control registers
  // ****
  logic [7:0] aux_sh_ff;
  logic [7:0] int_sh_ff;
  logic [4:0] pass_mask;
  always_ff @(posedge ref_clk) begin
    if (reset) aux_sh_ff <= 8'h00;
    else if (reg_wr && reg_addr == 5'h03) aux_sh_ff <= reg_wdata;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) int_sh_ff <= 8'h00;
    else if (reg_wr && reg_addr == 5'h02) int_sh_ff <= reg_wdata;
  end
  // Mask bit three drives the pin instead of masking while the pin is an output
  assign pass_mask = int_sh_ff[4:0] & ~{1'b0, aux_sh_ff[4], 3'b000};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_grant_lock: assert property (remote_grant == ($past(remote_req, 2) && !aux_sh_ff[1]))
    else $error("remote grant wrong");
  a_clock_hiz: assert property (clk_out_pin_oe == !aux_sh_ff[2])
    else $error("clock out enable wrong");
  a_pin_dir: assert property (reg_wr && reg_addr == 5'h03 |=>
    bidir_interrupt_pin_oe == $past(reg_wdata[4]))
    else $error("pin direction wrong");
  a_pin_drive: assert property (bidir_interrupt_pin_oe |->
    bidir_interrupt_pin_out == int_sh_ff[3])
    else $error("pin level wrong");
  a_gie_block: assert property (!aux_sh_ff[0] |-> irq_accepted == 5'h00)
    else $error("interrupt not blocked");
  a_mask_pass: assert property (aux_sh_ff[0] |->
    irq_accepted == (irq_requests & ~pass_mask))
    else $error("mask wrong");
  a_read_len: assert property (read_tstates == (aux_sh_ff[3] ? 3'h4 : 3'h3))
    else $error("read length wrong");
  a_strobe_late: assert property ($rose(aux_sh_ff[3]) |-> read_strobe_delay)
    else $error("strobe delay wrong");
endmodule
bind aux_ctrl aux_ctrl_chk u_chk (.ref_clk, .reset, .reg_wr, .reg_addr, .reg_wdata,
  .irq_requests, .irq_accepted, .bidir_interrupt_pin_out, .bidir_interrupt_pin_oe,
  .clk_out_pin_oe, .remote_req, .remote_grant, .read_tstates, .read_strobe_delay);
`default_nettype wire

// ---- tb/remote_host.sv ----
`default_nettype none
module remote_host (
  input  wire logic ref_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      remote_req,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_ff = 1'b1;
  logic req_ff = 1'b0;
  always @(posedge ref_clk) begin
    req_ff <= 1'($urandom);
    drv_ff <= 1'($urandom);
  end
  assign remote_req = req_ff;
  assign pin_level = pin_oe ? pin_out : drv_ff;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0;
  logic [4:0] reg_addr = 5'h00, irq_requests = 5'h00, irq_accepted;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [2:0] tstates;
  logic       pin_out, pin_oe, pin_in, clk_oe, remote_req, grant, slow_dly;
  logic       irq_take, clk_out;
  logic [1:0] req_hist;
  logic [4:0] exp_irq;
  int         bad_count = 0, checked = 0, aux_val, int_val;
  aux_ctrl DUT (.ref_clk, .reset, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .irq_requests,
    .irq_take(irq_take), .irq_accepted, .bidir_interrupt_pin_in(pin_in),
    .bidir_interrupt_pin_out(pin_out), .bidir_interrupt_pin_oe(pin_oe),
    .cpu_clk_level(ref_clk), .clk_out_pin_out(clk_out), .clk_out_pin_oe(clk_oe), .remote_req,
    .remote_grant(grant), .read_tstates(tstates), .read_strobe_delay(slow_dly));
  remote_host far_end (.ref_clk, .pin_out, .pin_oe, .remote_req, .pin_level(pin_in));
  initial forever #2 ref_clk = ~ref_clk;
  // The design passes the remote request through two flip-flops
  always @(posedge ref_clk) req_hist <= {req_hist[0], remote_req};
  task automatic end_of_test;
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    @(negedge ref_clk);
    chk(reg_rdata & m, e);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'h5c16_a92c));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(5'h03, 8'hff, 8'h00);
    for (int i = 0; i < 40; i++) begin
      aux_val = $urandom & 8'h3f;
      int_val = $urandom;
      wr(5'h02, int_val[7:0]);
      irq_requests <= 5'($urandom);
      wr(5'h03, aux_val[7:0]);
      rd(5'h03, 8'hff, aux_val[7:0]);
      exp_irq = int_val[4:0] & ~{1'b0, aux_val[4], 3'h0};
      exp_irq = aux_val[0] ? (irq_requests & ~exp_irq) : 5'h00;
      chk({3'h0, irq_accepted}, {3'h0, exp_irq});
      chk({6'h00, irq_take, clk_out}, {6'h00, |exp_irq, 1'b0});
      chk({7'h00, grant}, {7'h00, req_hist[1] & ~aux_val[1]});
      chk({6'h00, clk_oe, pin_oe}, {6'h00, ~aux_val[2], aux_val[4]});
      chk({4'h0, slow_dly, tstates}, aux_val[3] ? 8'h0c : 8'h03);
      if (aux_val[4]) chk({7'h00, pin_out}, {7'h00, int_val[3]});
      if (aux_val[4]) rd(5'h00, 8'h10, {3'h0, int_val[3], 4'h0});
    end
    wr(5'h04, 8'h03);
    wr(5'h05, 8'h00);
    wr(5'h03, 8'he0);
    repeat (2) @(posedge ref_clk);
    rd(5'h03, 8'hff, 8'ha0);
    repeat (20) @(posedge ref_clk);
    rd(5'h04, 8'hff, 8'h00);
    rd(5'h00, 8'h80, 8'h80);
    wr(5'h03, 8'h20);
    rd(5'h00, 8'h80, 8'h00);
    wr(5'h03, 8'he0);
    repeat (20) @(posedge ref_clk);
    wr(5'h00, 8'h80);
    rd(5'h00, 8'h80, 8'h00);
    wr(5'h03, 8'h20);
    wr(5'h04, 8'h08);
    wr(5'h03, 8'hc0);
    repeat (40) @(posedge ref_clk);
    rd(5'h04, 8'hff, 8'h06);
    wr(5'h03, 8'h00);
    repeat (40) @(posedge ref_clk);
    rd(5'h04, 8'hff, 8'h06);
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'hff, 8'h00);
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
